// *** hdp_power_ctrl.v ***
// Purpose: Fast power-up and power-down control of the transmit and receive paths.
// Assumes: Pins come from the back end, asynchronous to CORE_CLK; registers written on the register port.
// Notes: The transmit clock pin is sampled, not used as a clock; its edges time the off delay.
`default_nettype none
`include "hdp_map.vh"

module hdp_power_ctrl (
    input wire CORE_CLK,
    input wire SRST,
    input wire CE,
    input wire MASTER_POWER_PIN,
    input wire TRANSMIT_ENABLE_PIN,
    input wire RECEIVE_ENABLE_PIN,
    input wire TRANSMIT_QUIET_N_PIN,
    input wire TRANSMIT_CLOCK_PIN,
    input wire FULL_DUPLEX_MODE,
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire REG_WE,
    output reg [7:0] REG_RDATA,
    output reg [7:0] BLOCK_PD,
    output reg LINE_AMP_PD,
    output reg FILTER_FLUSH,
    output reg [2:0] COARSE_GAIN_BIAS,
    output reg [1:0] FINE_GAIN_BIAS,
    output reg [2:0] CONVERTER_BIAS
);

    // One-hot transmit power states.
    localparam [2:0] ST_ON = 3'h1;
    localparam [2:0] ST_WAIT = 3'h2;
    localparam [2:0] ST_OFF = 3'h4;

    wire [5:0] pins_s;
    wire master_s;
    wire transmit_enable_pin_s;
    wire receive_enable_pin_s;
    wire quiet_n_s;
    wire tclk_s;
    wire full_duplex_s;
    reg transmit_enable_pin_prev_q;
    reg receive_enable_pin_prev_q;
    reg tclk_prev_q;
    wire transmit_enable_pin_fall;
    wire transmit_enable_pin_rise;
    wire tclk_tick;
    reg [7:0] mask_low_q;
    reg [7:0] mask_high_q;
    reg [7:0] hd_ctrl_q;
    reg conv_lp_q;
    reg [7:0] bias_q;
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [4:0] dly_cnt_q;
    reg [4:0] dly_cnt_d;
    reg [5:0] flush_cnt_q;
    reg [5:0] flush_cnt_d;
    reg rx_pd_q;
    reg [7:0] mask_pd;
    reg [7:0] pd_d;
    reg amp_pd_d;
    wire tx_fast_en;
    wire rx_fast_en;
    wire tx_off;
    wire filter_off;

    // Picks one register by offset for readback.
    function [7:0] reg_read;
        input [7:0] addr;
        input [7:0] m_low;
        input [7:0] m_high;
        input [7:0] hd;
        input lp;
        input [7:0] bias;
        begin
            case (addr)
                `HDP_OFS_MASK_LOW: reg_read = m_low;
                `HDP_OFS_MASK_HIGH: reg_read = m_high;
                `HDP_OFS_HD_CTRL: reg_read = hd;
                `HDP_OFS_CONV_LP: reg_read = {3'h0, lp, 4'h0};
                `HDP_OFS_BIAS: reg_read = bias;
                default: reg_read = 8'h00;
            endcase
        end
    endfunction

    // All pins pass two flip-flops before any logic reads them.
    hdp_sync #(
        .WIDTH(6)
    ) u_sync (
        .clk(CORE_CLK),
        .ce(CE),
        .srst(SRST),
        .din({FULL_DUPLEX_MODE, TRANSMIT_CLOCK_PIN, TRANSMIT_QUIET_N_PIN,
              RECEIVE_ENABLE_PIN, TRANSMIT_ENABLE_PIN, MASTER_POWER_PIN}),
        .dout(pins_s)
    );

    assign master_s = pins_s[0];
    assign transmit_enable_pin_s = pins_s[1];
    assign receive_enable_pin_s = pins_s[2];
    assign quiet_n_s = pins_s[3];
    assign tclk_s = pins_s[4];
    assign full_duplex_s = pins_s[5];

    // Edge history of the synchronised transmit enable, receive enable and transmit clock pins.
    always @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            transmit_enable_pin_prev_q <= 1'b0;
            receive_enable_pin_prev_q <= 1'b0;
            tclk_prev_q <= 1'b0;
        end
        else if (CE)
        begin
            transmit_enable_pin_prev_q <= transmit_enable_pin_s;
            receive_enable_pin_prev_q <= receive_enable_pin_s;
            tclk_prev_q <= tclk_s;
        end
    end

    assign transmit_enable_pin_fall = transmit_enable_pin_prev_q & ~transmit_enable_pin_s;
    assign transmit_enable_pin_rise = ~transmit_enable_pin_prev_q & transmit_enable_pin_s;
    assign tclk_tick = ~tclk_prev_q & tclk_s;

    // Register writes; converter register keeps only its low-power bit.
    always @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            mask_low_q <= `HDP_RST_MASK_LOW;
            mask_high_q <= `HDP_RST_MASK_HIGH;
            hd_ctrl_q <= `HDP_RST_HD_CTRL;
            conv_lp_q <= 1'b0;
            bias_q <= `HDP_RST_BIAS;
        end
        else if (CE && REG_WE)
        begin
            case (REG_ADDR)
                `HDP_OFS_MASK_LOW: mask_low_q <= REG_WDATA;
                `HDP_OFS_MASK_HIGH: mask_high_q <= REG_WDATA;
                `HDP_OFS_HD_CTRL: hd_ctrl_q <= REG_WDATA;
                `HDP_OFS_CONV_LP: conv_lp_q <= REG_WDATA[`HDP_LP_BIT];
                `HDP_OFS_BIAS: bias_q <= REG_WDATA;
                default: bias_q <= bias_q;
            endcase
        end
    end

    // Readback is registered and returns zero for unmapped offsets.
    always @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            REG_RDATA <= 8'h00;
        end
        else if (CE)
        begin
            REG_RDATA <= reg_read(REG_ADDR, mask_low_q, mask_high_q, hd_ctrl_q, conv_lp_q, bias_q);
        end
    end

    // Transmit off-delay and flush sequencing.
    always @*
    begin
        state_d = state_q;
        dly_cnt_d = dly_cnt_q;
        flush_cnt_d = flush_cnt_q;
        case (state_q)
            ST_ON:
            begin
                if (transmit_enable_pin_fall)
                begin
                    dly_cnt_d = hd_ctrl_q[`HDP_HD_DELAY_MSB:`HDP_HD_DELAY_LSB];
                    flush_cnt_d = `HDP_FLUSH_CYCLES;
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (dly_cnt_q == 5'h00)
                begin
                    state_d = ST_OFF;
                end
                else if (tclk_tick)
                begin
                    dly_cnt_d = dly_cnt_q - 5'h01;
                end
            end
            ST_OFF:
            begin
                state_d = ST_OFF;
            end
            default:
            begin
                state_d = ST_ON;
            end
        endcase
        if (state_q != ST_ON && flush_cnt_q != 6'h00 && tclk_tick)
        begin
            flush_cnt_d = flush_cnt_q - 6'h01;
        end
        if (transmit_enable_pin_rise)
        begin
            state_d = ST_ON;
            dly_cnt_d = 5'h00;
            flush_cnt_d = 6'h00;
        end
    end

    always @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            state_q <= ST_ON;
            dly_cnt_q <= 5'h00;
            flush_cnt_q <= 6'h00;
        end
        else if (CE)
        begin
            state_q <= state_d;
            dly_cnt_q <= dly_cnt_d;
            flush_cnt_q <= flush_cnt_d;
        end
    end

    // Receive fast power state from the selected enable pin.
    always @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            rx_pd_q <= 1'b0;
        end
        else if (CE)
        begin
            if (hd_ctrl_q[`HDP_HD_RX_VIA_TX])
            begin
                if (transmit_enable_pin_rise)
                begin
                    rx_pd_q <= 1'b1;
                end
                else if (transmit_enable_pin_fall)
                begin
                    rx_pd_q <= 1'b0;
                end
            end
            else
            begin
                if (~receive_enable_pin_prev_q & receive_enable_pin_s)
                begin
                    rx_pd_q <= 1'b0;
                end
                else if (receive_enable_pin_prev_q & ~receive_enable_pin_s)
                begin
                    rx_pd_q <= 1'b1;
                end
            end
        end
    end

    assign tx_fast_en = ~full_duplex_s & hd_ctrl_q[`HDP_HD_TX_EN];
    assign rx_fast_en = ~full_duplex_s & hd_ctrl_q[`HDP_HD_RX_EN];
    assign tx_off = state_q == ST_OFF;
    assign filter_off = tx_off && flush_cnt_q == 6'h00;

    // Combines the pin-selected mask with the fast controls.
    always @*
    begin
        mask_pd = master_s ? mask_high_q : mask_low_q;
        pd_d = mask_pd;
        amp_pd_d = mask_pd[`HDP_PD_CONVERTER];
        if (full_duplex_s)
        begin
            if (!quiet_n_s)
            begin
                amp_pd_d = 1'b1;
                pd_d[`HDP_PD_TX_FILTER] = 1'b1;
            end
        end
        else
        begin
            if (tx_fast_en && tx_off)
            begin
                amp_pd_d = 1'b1;
            end
            if (tx_fast_en && filter_off)
            begin
                pd_d[`HDP_PD_TX_FILTER] = 1'b1;
            end
            if (rx_fast_en && rx_pd_q)
            begin
                pd_d[`HDP_PD_RX_CONV] = 1'b1;
                pd_d[`HDP_PD_RX_GAIN] = 1'b1;
            end
        end
    end

    // Registered power and bias outputs, a few cycles from the pin.
    always @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            BLOCK_PD <= 8'h00;
            LINE_AMP_PD <= 1'b0;
            FILTER_FLUSH <= 1'b0;
            COARSE_GAIN_BIAS <= 3'h0;
            FINE_GAIN_BIAS <= 2'h0;
            CONVERTER_BIAS <= 3'h0;
        end
        else if (CE)
        begin
            BLOCK_PD <= pd_d;
            LINE_AMP_PD <= amp_pd_d;
            FILTER_FLUSH <= ~full_duplex_s && state_q != ST_ON && flush_cnt_q != 6'h00;
            COARSE_GAIN_BIAS <= bias_q[`HDP_BIAS_COARSE_MSB:`HDP_BIAS_COARSE_LSB];
            FINE_GAIN_BIAS <= bias_q[`HDP_BIAS_FINE_MSB:`HDP_BIAS_FINE_LSB];
            CONVERTER_BIAS <= conv_lp_q ? `HDP_LP_CONV_BIAS : bias_q[`HDP_BIAS_CONV_MSB:`HDP_BIAS_CONV_LSB];
        end
    end

endmodule // hdp_power_ctrl

`default_nettype wire

// *** hdp_map.vh ***
// Purpose: Offsets, field positions, reset values and counts of the power block.
// Assumes: Included by the power control files and by the bench.
// Notes: Offsets are the byte addresses of the serial register port.
`ifndef HDP_MAP_VH
`define HDP_MAP_VH

// Register offsets.
`define HDP_OFS_MASK_LOW 8'h01
`define HDP_OFS_MASK_HIGH 8'h02
`define HDP_OFS_HD_CTRL 8'h03
`define HDP_OFS_CONV_LP 8'h07
`define HDP_OFS_BIAS 8'h13

// Reset values.
`define HDP_RST_MASK_LOW 8'h00
`define HDP_RST_MASK_HIGH 8'h7f
`define HDP_RST_HD_CTRL 8'hff
`define HDP_RST_CONV_LP 8'h00
`define HDP_RST_BIAS 8'h00

// Power mask bit positions.
`define HDP_PD_CONVERTER 6
`define HDP_PD_TX_FILTER 5
`define HDP_PD_RX_CONV 2
`define HDP_PD_RX_GAIN 0

// Half-duplex control fields.
`define HDP_HD_DELAY_MSB 7
`define HDP_HD_DELAY_LSB 3
`define HDP_HD_RX_VIA_TX 2
`define HDP_HD_TX_EN 1
`define HDP_HD_RX_EN 0

// Converter low-power bit and bias fields.
`define HDP_LP_BIT 4
`define HDP_BIAS_COARSE_MSB 7
`define HDP_BIAS_COARSE_LSB 5
`define HDP_BIAS_FINE_MSB 4
`define HDP_BIAS_FINE_LSB 3
`define HDP_BIAS_CONV_MSB 2
`define HDP_BIAS_CONV_LSB 0
`define HDP_LP_CONV_BIAS 3'h3

// Midscale flush length in transmit clock cycles.
`define HDP_FLUSH_CYCLES 6'h21

`endif

// *** hdp_sync.v ***
// Purpose: Two flip-flop synchroniser for a group of pin inputs.
// Assumes: Inputs are asynchronous to clk.
// Notes: The first stage feeds only the second stage.
`default_nettype none

module hdp_sync #(
    parameter WIDTH = 6
) (
    input wire clk,
    input wire ce,
    input wire srst,
    input wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);

    genvar i;

    // One two-stage chain per bit.
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            reg meta_q;
            reg sync_q;
            always @(posedge clk)
            begin
                if (srst)
                begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end
                else if (ce)
                begin
                    meta_q <= din[i];
                    sync_q <= meta_q;
                end
            end
            assign dout[i] = sync_q;
        end
    endgenerate

endmodule // hdp_sync

`default_nettype wire

// *** hdp_power_ctrl_props.sv ***
// Purpose: Concurrent checks on the power control ports.
// Assumes: One clock domain; bound to hdp_power_ctrl.
// Notes: Masks and control register are mirrored from the write port.
`default_nettype none
`include "hdp_map.vh"
module hdp_power_ctrl_props (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic CE,
    input wire logic MASTER_POWER_PIN,
    input wire logic TRANSMIT_ENABLE_PIN,
    input wire logic TRANSMIT_QUIET_N_PIN,
    input wire logic TRANSMIT_CLOCK_PIN,
    input wire logic FULL_DUPLEX_MODE,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WE,
    input wire logic [7:0] REG_RDATA,
    input wire logic [7:0] BLOCK_PD,
    input wire logic LINE_AMP_PD,
    input wire logic FILTER_FLUSH,
    input wire logic [2:0] COARSE_GAIN_BIAS,
    input wire logic [1:0] FINE_GAIN_BIAS
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ml_q, mh_q, hd_q;
    logic [6:0] rises_q;
    logic txc_q;
    wire logic [7:0] msel = MASTER_POWER_PIN ? mh_q : ml_q;
    wire logic arm = rises_q != 7'h7f && !FULL_DUPLEX_MODE && !TRANSMIT_ENABLE_PIN;
    // Mirror writes; count transmit clock rises since the last enable fall.
    always @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            ml_q <= `HDP_RST_MASK_LOW;
            mh_q <= `HDP_RST_MASK_HIGH;
            hd_q <= `HDP_RST_HD_CTRL;
            rises_q <= 7'h7f;
            txc_q <= 1'b0;
        end
        else if (CE)
        begin
            if (REG_WE && REG_ADDR == `HDP_OFS_MASK_LOW) ml_q <= REG_WDATA;
            if (REG_WE && REG_ADDR == `HDP_OFS_MASK_HIGH) mh_q <= REG_WDATA;
            if (REG_WE && REG_ADDR == `HDP_OFS_HD_CTRL) hd_q <= REG_WDATA;
            txc_q <= TRANSMIT_CLOCK_PIN;
            if (TRANSMIT_ENABLE_PIN) rises_q <= 7'h00;
            else if (TRANSMIT_CLOCK_PIN && !txc_q && rises_q < 7'h7e) rises_q <= rises_q + 7'h01;
        end
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    sequence bias_wr(logic [7:0] d);
        CE && REG_WE && REG_ADDR == `HDP_OFS_BIAS && REG_WDATA == d ##1 CE && !REG_WE;
    endsequence
    property bias_p;
        logic [7:0] d;
        (CE && REG_WE, d = REG_WDATA) ##0 bias_wr(d) |=> COARSE_GAIN_BIAS == d[7:5] && FINE_GAIN_BIAS == d[4:3];
    endproperty
    // Checks on readback, bias, masks and the fast transmit and receive control.
    chk_lp_readback: assert property (CE && REG_ADDR == `HDP_OFS_CONV_LP |=> (REG_RDATA & 8'hef) == 8'h00)
        else $error("low power readback has extra bits");
    chk_bias_fields: assert property (bias_p)
        else $error("bias fields differ from write");
    chk_fd_no_flush: assert property (FULL_DUPLEX_MODE [*5] |-> !FILTER_FLUSH)
        else $error("flush in full duplex");
    chk_quiet_off: assert property ((CE && FULL_DUPLEX_MODE && !TRANSMIT_QUIET_N_PIN && !REG_WE) [*6]
        |-> LINE_AMP_PD && BLOCK_PD[5] && BLOCK_PD[6] == msel[6])
        else $error("quiet low did not stop amplifier and filter");
    chk_mask_follow: assert property ((CE && FULL_DUPLEX_MODE && TRANSMIT_QUIET_N_PIN && !REG_WE
        && $stable(MASTER_POWER_PIN)) [*8] |-> BLOCK_PD == msel && LINE_AMP_PD == msel[6])
        else $error("power state differs from selected mask");
    chk_delay_early: assert property ($rose(LINE_AMP_PD) && arm && hd_q[1] && !msel[6]
        |-> rises_q >= {2'b00, hd_q[7:3]})
        else $error("amplifier off before delay elapsed");
    chk_flush_first: assert property ($rose(BLOCK_PD[5]) && arm && !msel[5] |-> rises_q >= 7'd33)
        else $error("filter off before flush done");
    chk_rx_via_tx: assert property (
        (CE && !FULL_DUPLEX_MODE && hd_q[2] && hd_q[0] && TRANSMIT_ENABLE_PIN && !REG_WE) [*6]
        |-> BLOCK_PD[2] && BLOCK_PD[0])
        else $error("receive path up during transmit");
endmodule // hdp_power_ctrl_props
bind hdp_power_ctrl hdp_power_ctrl_props i_props (.CORE_CLK(CORE_CLK), .SRST(SRST), .CE(CE),
    .MASTER_POWER_PIN(MASTER_POWER_PIN), .TRANSMIT_ENABLE_PIN(TRANSMIT_ENABLE_PIN),
    .TRANSMIT_QUIET_N_PIN(TRANSMIT_QUIET_N_PIN), .TRANSMIT_CLOCK_PIN(TRANSMIT_CLOCK_PIN),
    .FULL_DUPLEX_MODE(FULL_DUPLEX_MODE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WE(REG_WE),
    .REG_RDATA(REG_RDATA), .BLOCK_PD(BLOCK_PD), .LINE_AMP_PD(LINE_AMP_PD), .FILTER_FLUSH(FILTER_FLUSH),
    .COARSE_GAIN_BIAS(COARSE_GAIN_BIAS), .FINE_GAIN_BIAS(FINE_GAIN_BIAS));
`default_nettype wire

// *** hdp_backend.sv ***
// Purpose: Back end model driving transmit enable and the transmit clock.
// Assumes: Requests change just after a clock edge.
// Notes: The transmit clock stands still low outside a burst and its tail.
`default_nettype none
module hdp_backend (
    input wire logic clk,
    input wire logic tx_req,
    input wire logic clk_stall,
    output logic tx_en,
    output logic tx_clk = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ph_q = 3'h0;
    logic [5:0] tail_q = 6'h00;
    // zero fill
    // Samples are not modelled, so the filter always sees a quiet input.
    assign tx_en = tx_req;
    // clock tail
    // The clock keeps running 40 rises after the burst so the flush can finish.
    always @(posedge clk)
    begin
        ph_q <= (ph_q == 3'h4) ? 3'h0 : ph_q + 3'h1;
        if (tx_req)
            tail_q <= 6'h28;
        else if (ph_q == 3'h4 && !tx_clk && tail_q != 6'h00 && !clk_stall)
            tail_q <= tail_q - 6'h01;
        if (ph_q == 3'h4)
            tx_clk <= ((tx_req || tail_q != 6'h00) && !clk_stall) ? !tx_clk : 1'b0;
    end
endmodule // hdp_backend
`default_nettype wire

// *** tb.sv ***
// Purpose: Register and pin scenarios for the power control block.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes: Transmit clock rises are counted by the bench itself.
`default_nettype none
`include "hdp_map.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic CORE_CLK = 1'b0, SRST = 1'b1, CE = 1'b1, MASTER_POWER_PIN = 1'b0, RECEIVE_ENABLE_PIN = 1'b0;
    logic TRANSMIT_QUIET_N_PIN = 1'b1, FULL_DUPLEX_MODE = 1'b0, REG_WE = 1'b0, tx_req = 1'b0, clk_stall = 1'b0;
    logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00;
    wire logic [7:0] REG_RDATA, BLOCK_PD;
    wire logic TRANSMIT_ENABLE_PIN, TRANSMIT_CLOCK_PIN, LINE_AMP_PD, FILTER_FLUSH;
    wire logic [2:0] COARSE_GAIN_BIAS, CONVERTER_BIAS;
    wire logic [1:0] FINE_GAIN_BIAS;
    logic [7:0] ofs [5] = '{8'h01, 8'h02, 8'h03, 8'h07, 8'h13};
    logic [7:0] rst [5] = '{8'h00, 8'h7f, 8'hff, 8'h00, 8'h00};
    int n_mismatch = 0, n_compared = 0, cyc = 0, n1, n2;
    hdp_power_ctrl i_dut (.CORE_CLK(CORE_CLK), .SRST(SRST), .CE(CE), .MASTER_POWER_PIN(MASTER_POWER_PIN),
        .TRANSMIT_ENABLE_PIN(TRANSMIT_ENABLE_PIN), .RECEIVE_ENABLE_PIN(RECEIVE_ENABLE_PIN),
        .TRANSMIT_QUIET_N_PIN(TRANSMIT_QUIET_N_PIN), .TRANSMIT_CLOCK_PIN(TRANSMIT_CLOCK_PIN),
        .FULL_DUPLEX_MODE(FULL_DUPLEX_MODE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WE(REG_WE),
        .REG_RDATA(REG_RDATA), .BLOCK_PD(BLOCK_PD), .LINE_AMP_PD(LINE_AMP_PD), .FILTER_FLUSH(FILTER_FLUSH),
        .COARSE_GAIN_BIAS(COARSE_GAIN_BIAS), .FINE_GAIN_BIAS(FINE_GAIN_BIAS), .CONVERTER_BIAS(CONVERTER_BIAS));
    hdp_backend i_backend (.clk(CORE_CLK), .tx_req(tx_req), .clk_stall(clk_stall),
        .tx_en(TRANSMIT_ENABLE_PIN), .tx_clk(TRANSMIT_CLOCK_PIN));
    // The 200 MHz core clock.
    initial
    begin
        forever #2.5 CORE_CLK = ~CORE_CLK;
    end
    // Cut a hang short.
    always @(posedge CORE_CLK)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            results();
        end
    end
    task results();
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge CORE_CLK);
        #1;
    endtask
    // One write, then an idle cycle so the strobe never falls and rises in one time step.
    task wr(input logic [7:0] a, input logic [7:0] d);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WE = 1'b1;
        step(1);
        REG_WE = 1'b0;
        step(1);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        REG_ADDR = a;
        step(1);
        chk(REG_RDATA, exp);
    endtask
    // Wait for amplifier (w=0) or filter (w=1) power-down, counting clock rises.
    task wait_pd(input int w, output int n);
        logic p;
        int i;
        n = 0;
        p = TRANSMIT_CLOCK_PIN;
        for (i = 0; i < 3000; i++)
        begin
            step(1);
            if (TRANSMIT_CLOCK_PIN && !p) n++;
            p = TRANSMIT_CLOCK_PIN;
            if ((w == 0 && LINE_AMP_PD === 1'b1) || (w == 1 && BLOCK_PD[5] === 1'b1)) break;
        end
    endtask
    // Main sequence of scenarios.
    initial
    begin
        step(20);
        SRST = 1'b0;
        for (int i = 0; i < 5; i++) rd(ofs[i], rst[i]);
        for (int i = 0; i < 5; i++) wr(ofs[i], 8'h5a);
        for (int i = 0; i < 5; i++) rd(ofs[i], (ofs[i] == 8'h07) ? 8'h10 : 8'h5a);
        wr(8'h05, 8'hff);
        rd(8'h05, 8'h00);
        CE = 1'b0;
        wr(`HDP_OFS_BIAS, 8'hff);
        CE = 1'b1;
        rd(`HDP_OFS_BIAS, 8'h5a);
        wr(`HDP_OFS_BIAS, 8'hb6);
        wr(`HDP_OFS_CONV_LP, 8'h00);
        step(2);
        chk({COARSE_GAIN_BIAS, FINE_GAIN_BIAS, CONVERTER_BIAS}, 8'hb6);
        wr(`HDP_OFS_BIAS, 8'h00);
        wr(`HDP_OFS_CONV_LP, 8'h10);
        step(2);
        chk({5'h00, CONVERTER_BIAS}, 8'h03);
        FULL_DUPLEX_MODE = 1'b1;
        wr(`HDP_OFS_MASK_LOW, 8'h60);
        wr(`HDP_OFS_MASK_HIGH, 8'h05);
        step(8);
        chk({LINE_AMP_PD, BLOCK_PD[6:0]}, 8'he0);
        MASTER_POWER_PIN = 1'b1;
        step(6);
        chk({LINE_AMP_PD, BLOCK_PD[6:0]}, 8'h05);
        tx_req = 1'b1;
        step(8);
        chk({FILTER_FLUSH, BLOCK_PD[6:0]}, 8'h05);
        tx_req = 1'b0;
        TRANSMIT_QUIET_N_PIN = 1'b0;
        step(8);
        chk({LINE_AMP_PD, BLOCK_PD[6:0]}, 8'ha5);
        TRANSMIT_QUIET_N_PIN = 1'b1;
        FULL_DUPLEX_MODE = 1'b0;
        MASTER_POWER_PIN = 1'b0;
        wr(`HDP_OFS_MASK_LOW, 8'h00);
        wr(`HDP_OFS_HD_CTRL, 8'hff);
        tx_req = 1'b1;
        step(8);
        chk({LINE_AMP_PD, BLOCK_PD[6:0]}, 8'h05);
        tx_req = 1'b0;
        wait_pd(0, n1);
        chk({7'h00, n1 >= 31 && n1 <= 32}, 8'h01);
        chk({FILTER_FLUSH, BLOCK_PD[6:0]}, 8'h80);
        wait_pd(1, n2);
        chk({7'h00, n1 + n2 >= 33 && n1 + n2 <= 34}, 8'h01);
        tx_req = 1'b1;
        step(6);
        chk({LINE_AMP_PD, BLOCK_PD[6:0]}, 8'h05);
        wr(`HDP_OFS_HD_CTRL, 8'h07);
        clk_stall = 1'b1;
        tx_req = 1'b0;
        step(8);
        chk({LINE_AMP_PD, BLOCK_PD[6:0]}, 8'h80);
        tx_req = 1'b1;
        step(6);
        chk({7'h00, LINE_AMP_PD}, 8'h00);
        clk_stall = 1'b0;
        wr(`HDP_OFS_HD_CTRL, 8'hfc);
        step(8);
        chk({LINE_AMP_PD, BLOCK_PD[6:0]}, 8'h00);
        tx_req = 1'b0;
        step(8);
        chk({LINE_AMP_PD, BLOCK_PD[6:0]}, 8'h00);
        wr(`HDP_OFS_HD_CTRL, 8'h01);
        RECEIVE_ENABLE_PIN = 1'b1;
        step(6);
        chk(BLOCK_PD, 8'h00);
        RECEIVE_ENABLE_PIN = 1'b0;
        step(6);
        chk(BLOCK_PD, 8'h05);
        RECEIVE_ENABLE_PIN = 1'b1;
        step(6);
        chk(BLOCK_PD, 8'h00);
        results();
    end
endmodule // tb
`default_nettype wire
